// ### ptl_bit_timer.sv
// Bit-time enable divider for the transmit sequencer.
`timescale 1ns/10ps
`default_nettype none
module ptl_bit_timer #(
    parameter int CYCLES = 83
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Control.
    input wire logic run,
    output logic tick
);
    initial begin
        if (CYCLES < 2 || CYCLES > 255) begin
            $error("ptl_bit_timer: CYCLES out of range");
        end
    end
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } ptl_tmr_t;
    ptl_tmr_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 8'h00;
        end else if (s_q.cnt == 8'(CYCLES - 1)) begin
            s_d.cnt = 8'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule
`default_nettype wire

// ### ptl_launch_ctl.sv
// Transmit launch control: register, launch, reset and abort sequencing.
`timescale 1ns/10ps
`default_nettype none
module ptl_launch_ctl
    import ptl_pkg::*;
#(
    parameter int BIT_CYCLES = ptl_pkg::PTL_BIT_CYCLES,
    parameter int PREAMBLE_BITS = ptl_pkg::PTL_PREAMBLE_BITS,
    parameter int PACKET_NIBBLES = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic protocol_block_reset,
    // Register port.
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Neighbouring controls and line status.
    input wire logic raw_mode_enable,
    input wire logic line_busy,
    input wire logic auto_response_busy,
    input wire logic collision,
    // Transmit side outputs.
    output logic tx_active,
    output ptl_pkg::ptl_kind_t tx_kind,
    output logic tx_phase_preamble,
    output logic queue_write_pointer_reset,
    output logic end_of_packet_sent_flag,
    output logic tx_aborted_flag
);
    initial begin
        if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 127 ||
            PACKET_NIBBLES < 1 || PACKET_NIBBLES > 255) begin
            $error("ptl_launch_ctl: parameter out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        ptl_state_t st;
        ptl_kind_t kind;
        logic launch;
        logic hard;
        logic cable;
        logic clear;
        logic abort_pend;
        logic [7:0] bits;
        logic [7:0] units;
        logic [7:0] rdata;
        logic ptr_rst;
        logic eop_flag;
        logic abt_flag;
        logic preamble;
    } ptl_ctl_t;

    ptl_ctl_t s_q, s_d;
    logic tick;

    ptl_bit_timer #(
        .CYCLES(BIT_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .run(s_q.st != PTL_IDLE),
        .tick(tick)
    );

    function automatic logic [7:0] ctl_read(input ptl_ctl_t s);
        logic [7:0] v;
        v = 8'h00; // [RQ19]
        v[PTL_BIT_LAUNCH] = s.launch;
        v[PTL_BIT_HARD] = s.hard;
        v[PTL_BIT_CABLE] = s.cable;
        v[PTL_BIT_CLEAR] = s.clear; // [RQ8]
        return v; // [RQ11] [RQ13]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic sel;
        logic wr_hard;
        logic wr_cable;
        logic done;
        sel = (reg_addr == PTL_CTL_ADDR);
        wr_hard = 1'b0;
        wr_cable = 1'b0;
        done = 1'b0;
        s_d = s_q;
        s_d.ptr_rst = 1'b0;
        s_d.eop_flag = 1'b0;
        s_d.abt_flag = 1'b0;
        s_d.clear = !(line_busy || auto_response_busy); // [RQ9]
        if (sel && reg_rd) begin
            s_d.rdata = ctl_read(s_q);
        end
        if (sel && reg_wr) begin
            if (reg_wdata[PTL_BIT_PTRCLR]) begin
                s_d.ptr_rst = 1'b1; // [RQ10]
            end
            if (!s_q.launch) begin
                wr_hard = reg_wdata[PTL_BIT_HARD]; // [RQ3]
                wr_cable = reg_wdata[PTL_BIT_CABLE] && !wr_hard &&
                    !s_q.hard; // [RQ4]
                if (wr_hard) begin
                    s_d.hard = 1'b1; // [RQ5]
                end
                if (wr_cable) begin
                    s_d.cable = 1'b1;
                end
            end
            if (reg_wdata[PTL_BIT_ABORT] && s_q.st != PTL_IDLE) begin
                s_d.abort_pend = 1'b1; // [RQ13]
            end
            if (reg_wdata[PTL_BIT_LAUNCH] && !s_q.launch) begin
                s_d.launch = 1'b1; // [RQ16]
                s_d.st = PTL_PREAMBLE;
                s_d.bits = 8'h00;
                s_d.units = 8'h00;
                s_d.abort_pend = 1'b0;
                if (raw_mode_enable) begin
                    s_d.kind = PTL_KIND_PACKET; // [RQ2]
                end else if (s_q.hard || wr_hard) begin
                    s_d.kind = PTL_KIND_HARD; // [RQ12]
                end else if (s_q.cable || wr_cable) begin
                    s_d.kind = PTL_KIND_CABLE; // [RQ1]
                end else begin
                    s_d.kind = PTL_KIND_PACKET;
                end
            end
        end
        if (collision && s_q.st != PTL_IDLE) begin
            s_d.abort_pend = 1'b1; // [RQ18]
            s_d.abt_flag = 1'b1;
        end
        if (tick) begin
            case (s_q.st)
                PTL_PREAMBLE: begin
                    s_d.bits = s_q.bits + 8'h01;
                    if (s_d.abort_pend) begin
                        s_d.st = PTL_EOP; // [RQ14]
                        s_d.bits = 8'h00;
                    end else if (s_q.bits == 8'(PREAMBLE_BITS - 1)) begin
                        s_d.st = PTL_BODY;
                        s_d.bits = 8'h00;
                    end
                end
                PTL_BODY: begin
                    s_d.bits = s_q.bits + 8'h01;
                    if (s_q.bits == 8'(PTL_NIBBLE_BITS - 1)) begin
                        s_d.bits = 8'h00;
                        s_d.units = s_q.units + 8'h01;
                        if (s_d.abort_pend || s_q.kind != PTL_KIND_PACKET ||
                            s_q.units == 8'(PACKET_NIBBLES - 1)) begin
                            s_d.st = PTL_EOP; // [RQ14]
                        end
                    end
                end
                PTL_EOP: begin
                    s_d.bits = s_q.bits + 8'h01;
                    if (s_q.bits == 8'(PTL_EOP_BITS - 1)) begin
                        done = 1'b1;
                    end
                end
                default: begin
                    s_d.bits = 8'h00;
                end
            endcase
        end
        if (done) begin
            s_d.st = PTL_IDLE; // [RQ6]
            s_d.launch = 1'b0; // [RQ17]
            s_d.hard = 1'b0; // [RQ5]
            s_d.cable = 1'b0;
            s_d.abort_pend = 1'b0;
            s_d.eop_flag = 1'b1;
            s_d.ptr_rst = 1'b1; // [RQ11]
        end
        if (protocol_block_reset) begin
            s_d.st = PTL_IDLE;
            s_d.launch = PTL_RST_LAUNCH; // [RQ17]
            s_d.hard = PTL_RST_HARD; // [RQ5]
            s_d.cable = PTL_RST_CABLE;
            s_d.abort_pend = 1'b0;
            s_d.bits = 8'h00;
            s_d.units = 8'h00;
        end
        // Preamble phase output is kept in its own flip-flop.
        s_d.preamble = (s_d.st == PTL_PREAMBLE);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= PTL_IDLE;
            s_q.kind <= PTL_KIND_PACKET;
            s_q.clear <= PTL_RST_CLEAR; // [RQ8]
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata = s_q.rdata;
    assign tx_active = s_q.launch;
    assign tx_kind = s_q.kind;
    assign tx_phase_preamble = s_q.preamble;
    assign queue_write_pointer_reset = s_q.ptr_rst;
    assign end_of_packet_sent_flag = s_q.eop_flag; // [RQ15]
    assign tx_aborted_flag = s_q.abt_flag;
endmodule
`default_nettype wire

// ### ptl_launch_ctl_assertions.sv
// Assertion checker for the transmit launch control block.
`timescale 1ns/10ps
`default_nettype none
module ptl_launch_ctl_assertions
    import ptl_pkg::*;
#(
    parameter int BIT_CYCLES = 83
) (
    // Clock and resets.
    input wire logic clk,
    input wire logic rst,
    input wire logic protocol_block_reset,
    // Register port.
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Line status and transmit side.
    input wire logic raw_mode_enable,
    input wire logic line_busy,
    input wire logic auto_response_busy,
    input wire logic collision,
    input wire logic tx_active,
    input wire ptl_pkg::ptl_kind_t tx_kind,
    input wire logic queue_write_pointer_reset,
    input wire logic end_of_packet_sent_flag,
    input wire logic tx_aborted_flag
);
    localparam int AMAX = (2 + PTL_NIBBLE_BITS + PTL_EOP_BITS) * BIT_CYCLES;
    logic go_w;
    logic go_r;
    assign go_w = reg_wr && reg_addr == PTL_CTL_ADDR && !protocol_block_reset;
    assign go_r = reg_rd && reg_addr == PTL_CTL_ADDR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    AST_RSV: assert property (
        go_r |=> (reg_rdata & 8'hca) == 8'h00) else $error("bad zero bits");
    AST_BUSY: assert property (
        (line_busy || auto_response_busy) [*2] ##0 go_r |=> !reg_rdata[4])
        else $error("clear flag high while busy");
    AST_GO: assert property (
        go_w && reg_wdata[0] && !tx_active |=> tx_active) else $error("no start");
    AST_HARD: assert property (
        go_w && reg_wdata == 8'h05 && !tx_active && !raw_mode_enable
        |=> tx_kind == PTL_KIND_HARD) else $error("hard Reset not sent");
    AST_RAW: assert property (
        go_w && reg_wdata[0] && !tx_active && raw_mode_enable
        |=> tx_kind == PTL_KIND_PACKET) else $error("raw mode not packet");
    AST_END: assert property (
        $fell(tx_active) && !$past(protocol_block_reset)
        |-> end_of_packet_sent_flag && queue_write_pointer_reset)
        else $error("end pulses missing");
    AST_ABORT: assert property (
        go_w && reg_wdata[1] && tx_active
        |-> ##[1:AMAX] (end_of_packet_sent_flag || protocol_block_reset))
        else $error("abort too slow");
    AST_COLL: assert property (
        $rose(collision) && tx_active && !protocol_block_reset
        |=> tx_aborted_flag) else $error("collision not flagged");
    COV_HARD: cover property (go_w && reg_wdata == 8'h05 && !tx_active);
    COV_ABORT: cover property (go_w && reg_wdata[1] && tx_active);
    COV_COLL: cover property (tx_aborted_flag);
endmodule
bind ptl_launch_ctl ptl_launch_ctl_assertions #(.BIT_CYCLES(BIT_CYCLES)) i_chk (
    .clk, .rst, .protocol_block_reset, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .raw_mode_enable, .line_busy,
    .auto_response_busy, .collision, .tx_active, .tx_kind,
    .queue_write_pointer_reset, .end_of_packet_sent_flag, .tx_aborted_flag
);
`default_nettype wire

// ### ptl_partner.sv
// Port partner model on the far side of the transmit line.
`timescale 1ns/10ps
`default_nettype none
module ptl_partner
    import ptl_pkg::*;
(
    // Clock, reset and bench commands.
    input wire logic clk,
    input wire logic rst,
    input wire logic talk,
    input wire logic jam,
    // Transmit side of the block.
    input wire logic tx_active,
    input wire ptl_pkg::ptl_kind_t tx_kind,
    input wire logic eop_seen,
    // Line status toward the block.
    output logic line_busy,
    output logic auto_response_busy,
    output logic collision
);
    logic [3:0] resp_q;
    logic jam_q;
    ptl_kind_t kind_q;
    assign line_busy = talk;
    assign auto_response_busy = resp_q != 4'h0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_q <= 4'h0;
            jam_q <= 1'b0;
            kind_q <= PTL_KIND_PACKET;
            collision <= 1'b0;
        end else begin
            if (tx_active) kind_q <= tx_kind;
            // Only a packet is answered; a Reset gets no feedback.
            if (eop_seen && kind_q == PTL_KIND_PACKET) resp_q <= 4'h6;
            else if (resp_q != 4'h0) resp_q <= resp_q - 4'h1;
            jam_q <= jam;
            collision <= jam && !jam_q && tx_active;
        end
    end
endmodule
`default_nettype wire

// ### ptl_pkg.sv
// Package with constants and types of the transmit launch control block.
// Operation
// RQ1: Cable reset with launch in automatic mode sends cable Reset, ignores queue.
// RQ2: Raw mode ignores both reset request bits.
// RQ3: Reset request bits set only while launch bit is clear.
// RQ4: Hard reset wins; cable request not set when both written.
// RQ5: Reset requests cleared by hardware at packet end or block reset only.
// RQ6: Reset transmissions are never retried automatically.
// RQ7: Software sets reset requests only after launch bit cleared.
// RQ8: Read-only channel clear flag resets to one; software checks before launch.
// RQ9: Channel clear is zero while line busy or auto response pending.
// RQ10: Writing one to pointer clear resets queue write pointer.
// RQ11: Pointer clear reads zero; pointer also cleared when launch bit clears. Code pulses it only at completion, not when block reset clears launch.
// RQ12: Hard reset with launch in automatic mode sends hard Reset, ignores queue.
// RQ13: Abort write stops transmission soon; zero no effect; reads zero.
// RQ14: Abort finishes nibble or preamble bit, sends end-of-packet, stops.
// RQ15: Software waits for end-of-packet sent flag after abort.
// RQ16: Launch starts queued packet, or requested Reset in automatic mode.
// RQ17: Launch bit cleared by hardware at completion or reset, not software.
// RQ18: Collision may abort; sets aborted flag and interrupt pulse.
// RQ19: Two top reserved bits read zero, writes ignored.
package ptl_pkg;
    localparam logic [15:0] PTL_CTL_ADDR = 16'h1a05;
    localparam int PTL_BIT_LAUNCH = 0;
    localparam int PTL_BIT_ABORT = 1;
    localparam int PTL_BIT_HARD = 2;
    localparam int PTL_BIT_PTRCLR = 3;
    localparam int PTL_BIT_CLEAR = 4;
    localparam int PTL_BIT_CABLE = 5;
    localparam logic PTL_RST_LAUNCH = 1'b0;
    localparam logic PTL_RST_HARD = 1'b0;
    localparam logic PTL_RST_CABLE = 1'b0;
    localparam logic PTL_RST_CLEAR = 1'b1;
    localparam int PTL_BIT_CYCLES = 83;
    localparam int PTL_PREAMBLE_BITS = 64;
    localparam int PTL_NIBBLE_BITS = 5;
    localparam int PTL_EOP_BITS = 5;
    typedef enum logic [1:0] {
        PTL_KIND_PACKET,
        PTL_KIND_HARD,
        PTL_KIND_CABLE
    } ptl_kind_t;
    typedef enum logic [2:0] {
        PTL_IDLE,
        PTL_PREAMBLE,
        PTL_BODY,
        PTL_EOP
    } ptl_state_t;
endpackage

// ### tb_ptl_launch_ctl.sv
// Testbench for the transmit launch control block.
`timescale 1ns/10ps
`default_nettype none
module tb_ptl_launch_ctl;
    import ptl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic protocol_block_reset = 1'b0;
    logic [15:0] reg_addr = PTL_CTL_ADDR;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic raw_mode_enable = 1'b0;
    logic talk = 1'b0;
    logic jam = 1'b0;
    logic seen_abort = 1'b0;
    logic [7:0] reg_rdata;
    logic line_busy, auto_response_busy, collision, tx_active;
    logic tx_phase_preamble, queue_write_pointer_reset;
    logic end_of_packet_sent_flag, tx_aborted_flag;
    ptl_kind_t tx_kind;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    ptl_launch_ctl #(.BIT_CYCLES(2), .PREAMBLE_BITS(4), .PACKET_NIBBLES(2)) i_dut (
        .clk, .rst, .protocol_block_reset, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .raw_mode_enable, .line_busy,
        .auto_response_busy, .collision, .tx_active, .tx_kind,
        .tx_phase_preamble, .queue_write_pointer_reset,
        .end_of_packet_sent_flag, .tx_aborted_flag
    );
    ptl_partner i_far (
        .clk, .rst, .talk, .jam, .tx_active, .tx_kind,
        .eop_seen(end_of_packet_sent_flag), .line_busy,
        .auto_response_busy, .collision
    );
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (tx_aborted_flag === 1'b1) seen_abort <= 1'b1;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1;
        chk("control", e, reg_rdata);
    endtask
    task automatic wait_eop(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (end_of_packet_sent_flag !== 1'b1 && n < lim);
        chk("eop", 8'h01, {7'h0, end_of_packet_sent_flag});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(8'h10);
        wr(8'hc2);
        rd(8'h10);
        wr(8'h08);
        #1;
        chk("ptr", 8'h01, {7'h0, queue_write_pointer_reset});
        rd(8'h10);
        reg_addr <= 16'h1a06;
        wr(8'h01);
        reg_addr <= PTL_CTL_ADDR;
        rd(8'h10);
        wr(8'h24);
        rd(8'h14);
        wr(8'h00);
        rd(8'h14);
        wr(8'h01);
        #1;
        chk("kind", {6'h0, PTL_KIND_HARD}, {6'h0, tx_kind});
        wr(8'h20);
        rd(8'h15);
        wait_eop(60);
        repeat (4) @(posedge clk);
        rd(8'h10);
        wr(8'h21);
        #1;
        chk("kind", {6'h0, PTL_KIND_CABLE}, {6'h0, tx_kind});
        wait_eop(60);
        raw_mode_enable <= 1'b1;
        wr(8'h05);
        #1;
        chk("kind", {6'h0, PTL_KIND_PACKET}, {6'h0, tx_kind});
        wait_eop(60);
        raw_mode_enable <= 1'b0;
        repeat (2) @(posedge clk);
        rd(8'h00);
        talk <= 1'b1;
        rd(8'h00);
        talk <= 1'b0;
        repeat (8) @(posedge clk);
        wr(8'h01);
        #1;
        chk("pre", 8'h01, {7'h0, tx_phase_preamble});
        wr(8'h02);
        wait_eop(16);
        wr(8'h01);
        repeat (9) @(posedge clk);
        wr(8'h02);
        wait_eop(22);
        wr(8'h01);
        jam <= 1'b1;
        wait_eop(60);
        jam <= 1'b0;
        chk("aborted", 8'h01, {7'h0, seen_abort});
        wr(8'h05);
        protocol_block_reset <= 1'b1;
        @(posedge clk);
        protocol_block_reset <= 1'b0;
        repeat (8) @(posedge clk);
        rd(8'h10);
        end_sim();
    end
endmodule
`default_nettype wire
